//--- include/core_state_regs.vh
/*
 * offsets, field positions and reset values of the core state registers.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CORE_STATE_REGS_VH
`define CORE_STATE_REGS_VH

// ----------------------------------------------------------------
// i/o offsets
// ----------------------------------------------------------------
`define SP_LOW_IO_ADDR        6'h3d
`define SP_HIGH_IO_ADDR       6'h3e
`define FLAGS_IO_ADDR         6'h3f
`define IO_DATA_BASE          16'h0020
`define IO_DATA_LAST          16'h005f
`define REGFILE_DATA_LAST     16'h001f

// ----------------------------------------------------------------
// processor flag fields
// ----------------------------------------------------------------
`define FLAG_IRQ_EN           7
`define FLAG_BIT_COPY         6
`define FLAG_HALF_CARRY       5
`define FLAG_SIGN             4
`define FLAG_OVERFLOW         3
`define FLAG_NEGATIVE         2
`define FLAG_ZERO             1
`define FLAG_CARRY            0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FLAGS_RESET           8'h00
`define SP_LOW_RESET          8'h00
`define SP_HIGH_RESET         8'h00

// ----------------------------------------------------------------
// pointer pairs
// ----------------------------------------------------------------
`define PTR_X_LOW             5'h1a
`define PTR_Y_LOW             5'h1c
`define PTR_Z_LOW             5'h1e

// ----------------------------------------------------------------
// pointer modes
// ----------------------------------------------------------------
`define PTR_MODE_PLAIN        2'h0
`define PTR_MODE_POST_INC     2'h1
`define PTR_MODE_PRE_DEC      2'h2
`define PTR_MODE_DISP         2'h3

// ----------------------------------------------------------------
// stack operations
// ----------------------------------------------------------------
`define STK_NONE              3'h0
`define STK_PUSH_BYTE         3'h1
`define STK_POP_BYTE          3'h2
`define STK_CALL              3'h3
`define STK_RETURN            3'h4
`define STK_IRQ_ENTRY         3'h5
`define STK_IRQ_RETURN        3'h6

`endif

//--- rtl/core_state.v
/*
 * architectural state of the 8-bit core: flags, working registers,
 * pointer pairs and stack pointer.
 * assumes the execution unit and alu drive the control ports on core_clk.
 */
`timescale 1ns/1ns
`include "core_state_regs.vh"

// Overview of operation
// - bit 7 is global interrupt enable; clear blocks every interrupt.
// - taking an interrupt clears the enable; interrupt return sets it.
// - set-interrupt and clear-interrupt instructions set and clear the enable.
// - bit 6 copy flag: bit store loads it, bit load writes it to register.
// - bit 5 half carry records low nibble carry when the operation updates it.
// - bit 4 sign is always negative xor overflow.
// - bit 3 holds two's complement overflow from arithmetic.
// - bit 2 negative is result msb.
// - bit 1 zero set on zero result, cleared otherwise.
// - bit 0 carry records carry or borrow.
// - register file gives 8 or 16 bit reads and 8 or 16 bit write-back.
// - data addresses 0x00 to 0x1f reach the working registers.
// - registers 26 to 31 form three pointers, low byte in even register.
// - pointers support displacement, post-increment and pre-decrement.
// - stack grows downward; pointer addresses the top.
// - push decrements by one; call or interrupt entry by two.
// - pop increments by one; return or interrupt return by two.
// - stack pointer is two read/write i/o bytes at 0x3e and 0x3d, reset zero.
// - half carry, overflow, negative, zero and carry update after an alu operation only if set in alu_flag_mask; sign always follows them.
// - flags are not saved or restored around interrupts.

module core_state
(
    input  wire        core_clk,
    input  wire        sys_rst,
    // interrupt control
    input  wire        irq_pending,
    input  wire        irq_take,
    input  wire        set_irq_instr,
    input  wire        clear_irq_instr,
    input  wire        return_from_irq_instr,
    output wire        irq_allowed,
    // alu flag update
    input  wire        alu_valid,
    input  wire [7:0]  alu_result,
    input  wire        alu_carry,
    input  wire        alu_half_carry,
    input  wire        alu_overflow,
    input  wire [7:0]  alu_flag_mask,
    // bit copy
    input  wire        bit_store_instr,
    input  wire        bit_load_instr,
    input  wire [2:0]  bit_sel,
    // register file
    input  wire [4:0]  rd_a_sel,
    input  wire [4:0]  rd_b_sel,
    output wire [7:0]  rd_a_data,
    output wire [7:0]  rd_b_data,
    output wire [15:0] rd_word_data,
    input  wire [4:0]  wr_sel,
    input  wire        wr_byte_en,
    input  wire        wr_word_en,
    input  wire [15:0] wr_data,
    // pointer addressing
    input  wire        ptr_en,
    input  wire [1:0]  ptr_sel,
    input  wire [1:0]  ptr_mode,
    input  wire [5:0]  ptr_disp,
    output reg  [15:0] ptr_addr,
    output wire        ptr_hits_regfile,
    // data-space access to the register file
    input  wire        data_wr_en,
    input  wire [15:0] data_addr,
    input  wire [7:0]  data_wr,
    output wire [7:0]  data_rd,
    // stack
    input  wire [2:0]  stack_op,
    output wire [15:0] stack_ptr,
    output reg  [15:0] stack_addr,
    // i/o space
    input  wire [5:0]  io_addr,
    input  wire        io_wr_en,
    input  wire [7:0]  io_wr,
    output reg  [7:0]  io_rd,
    output reg         io_hit,
    output wire [7:0]  processor_flags_out
);

    reg  [7:0]  processor_flags;
    reg  [7:0]  stack_ptr_low_byte;
    reg  [7:0]  stack_ptr_high_byte;
    reg  [7:0]  next_flags;
    reg  [15:0] next_sp;
    reg  [15:0] next_ptr;
    reg  [4:0]  ptr_low_reg;
    wire [15:0] ptr_value;
    wire        sp_write;
    wire [7:0]  rf_a_raw;
    wire        data_in_regfile;
    reg  [4:0]  rf_wr_sel;
    reg         rf_byte_en;
    reg  [15:0] rf_wr_data;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    function [7:0] set_bit;
        input [7:0] value;
        input [2:0] pos;
        input       bit_val;
        begin
            set_bit      = value;
            set_bit[pos] = bit_val;
        end
    endfunction

    function in_regfile;
        input [15:0] addr;
        begin
            in_regfile = (addr <= `REGFILE_DATA_LAST);
        end
    endfunction

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    assign data_in_regfile = data_wr_en & in_regfile(data_addr);

    always @*
    begin
        rf_wr_sel  = wr_sel;
        rf_byte_en = wr_byte_en;
        rf_wr_data = wr_data;
        if (bit_load_instr)
        begin
            rf_wr_sel  = rd_a_sel;
            rf_byte_en = 1'b1;
            rf_wr_data = {8'h00, set_bit(rf_a_raw, bit_sel,
                                         processor_flags[`FLAG_BIT_COPY])};
        end
        else if (data_in_regfile)
        begin
            rf_wr_sel  = data_addr[4:0];
            rf_byte_en = 1'b1;
            rf_wr_data = {8'h00, data_wr};
        end
    end

    working_regs u_regs
    (
        .core_clk       (core_clk),
        .rd_a_sel       (rd_a_sel),
        .rd_b_sel       (in_regfile(data_addr) ? data_addr[4:0] : rd_b_sel),
        .rd_a_data      (rf_a_raw),
        .rd_b_data      (rd_b_data),
        .rd_word_data   (rd_word_data),
        .rd_ptr_low_sel (ptr_low_reg),
        .rd_ptr_data    (ptr_value),
        .wr_sel         (rf_wr_sel),
        .wr_byte_en     (rf_byte_en),
        .wr_word_en     (wr_word_en & ~bit_load_instr),
        .wr_data        (rf_wr_data),
        .wr_ptr_en      (ptr_en & (ptr_mode == `PTR_MODE_POST_INC || ptr_mode == `PTR_MODE_PRE_DEC)),
        .wr_ptr_low_sel (ptr_low_reg),
        .wr_ptr_data    (next_ptr)
    );

    assign rd_a_data = rf_a_raw;
    assign data_rd   = rd_b_data;

    // ----------------------------------------------------------------
    // pointer pairs
    // ----------------------------------------------------------------
    always @*
    begin
        case (ptr_sel)
            2'h0:    ptr_low_reg = `PTR_X_LOW;
            2'h1:    ptr_low_reg = `PTR_Y_LOW;
            default: ptr_low_reg = `PTR_Z_LOW;
        endcase
        next_ptr = ptr_value;
        ptr_addr = ptr_value;
        case (ptr_mode)
            `PTR_MODE_POST_INC:
            begin
                next_ptr = ptr_value + 16'h0001;
            end
            `PTR_MODE_PRE_DEC:
            begin
                next_ptr = ptr_value - 16'h0001;
                ptr_addr = next_ptr;
            end
            `PTR_MODE_DISP:
            begin
                ptr_addr = ptr_value + {10'h000, ptr_disp};
            end
            default:
            begin
                ptr_addr = ptr_value;
            end
        endcase
    end

    assign ptr_hits_regfile = in_regfile(ptr_addr);

    // ----------------------------------------------------------------
    // processor flags
    // ----------------------------------------------------------------
    always @*
    begin
        next_flags = processor_flags;
        if (alu_valid)
        begin
            if (alu_flag_mask[`FLAG_HALF_CARRY])
                next_flags[`FLAG_HALF_CARRY] = alu_half_carry;
            if (alu_flag_mask[`FLAG_OVERFLOW])
                next_flags[`FLAG_OVERFLOW] = alu_overflow;
            if (alu_flag_mask[`FLAG_NEGATIVE])
                next_flags[`FLAG_NEGATIVE] = alu_result[7];
            if (alu_flag_mask[`FLAG_ZERO])
                next_flags[`FLAG_ZERO] = (alu_result == 8'h00);
            if (alu_flag_mask[`FLAG_CARRY])
                next_flags[`FLAG_CARRY] = alu_carry;
        end
        if (bit_store_instr)
            next_flags[`FLAG_BIT_COPY] = rf_a_raw[bit_sel];
        if (io_wr_en && io_addr == `FLAGS_IO_ADDR)
            next_flags = io_wr;
        if (set_irq_instr || return_from_irq_instr)
            next_flags[`FLAG_IRQ_EN] = 1'b1;
        if (clear_irq_instr || (irq_take && irq_allowed))
            next_flags[`FLAG_IRQ_EN] = 1'b0;
        next_flags[`FLAG_SIGN] = next_flags[`FLAG_NEGATIVE] ^ next_flags[`FLAG_OVERFLOW];
    end

    // flags are left alone on interrupt entry and return apart from the enable
    always @(posedge core_clk)
    begin
        if (sys_rst)
            processor_flags <= `FLAGS_RESET;
        else
            processor_flags <= next_flags;
    end

    assign irq_allowed         = processor_flags[`FLAG_IRQ_EN] & irq_pending & ~clear_irq_instr;
    assign processor_flags_out = processor_flags;

    // ----------------------------------------------------------------
    // stack pointer
    // ----------------------------------------------------------------
    assign stack_ptr = {stack_ptr_high_byte, stack_ptr_low_byte};
    assign sp_write  = io_wr_en & (io_addr == `SP_LOW_IO_ADDR || io_addr == `SP_HIGH_IO_ADDR);

    always @*
    begin
        next_sp    = stack_ptr;
        stack_addr = stack_ptr;
        case (stack_op)
            `STK_PUSH_BYTE:
                next_sp = stack_ptr - 16'h0001;
            `STK_CALL, `STK_IRQ_ENTRY:
                next_sp = stack_ptr - 16'h0002;
            `STK_POP_BYTE:
            begin
                next_sp    = stack_ptr + 16'h0001;
                stack_addr = next_sp;
            end
            `STK_RETURN, `STK_IRQ_RETURN:
            begin
                next_sp    = stack_ptr + 16'h0002;
                stack_addr = stack_ptr + 16'h0001;
            end
            default:
                next_sp = stack_ptr;
        endcase
    end

    // software must load the pointer above the i/o area before use
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            stack_ptr_low_byte  <= `SP_LOW_RESET;
            stack_ptr_high_byte <= `SP_HIGH_RESET;
        end
        else if (sp_write)
        begin
            if (io_addr == `SP_LOW_IO_ADDR)
                stack_ptr_low_byte <= io_wr;
            else
                stack_ptr_high_byte <= io_wr;
        end
        else
        begin
            stack_ptr_low_byte  <= next_sp[7:0];
            stack_ptr_high_byte <= next_sp[15:8];
        end
    end

    // ----------------------------------------------------------------
    // i/o read
    // ----------------------------------------------------------------
    always @*
    begin
        io_hit = 1'b1;
        case (io_addr)
            `SP_LOW_IO_ADDR:  io_rd = stack_ptr_low_byte;
            `SP_HIGH_IO_ADDR: io_rd = stack_ptr_high_byte;
            `FLAGS_IO_ADDR:   io_rd = processor_flags;
            default:
            begin
                io_rd  = 8'h00;
                io_hit = 1'b0;
            end
        endcase
    end

endmodule

//--- rtl/working_regs.v
/*
 * 32 x 8 working register file with 8 and 16 bit ports.
 * assumes writes from the execution unit on the core clock.
 */
`timescale 1ns/1ns
`include "core_state_regs.vh"

module working_regs
(
    input  wire        core_clk,
    input  wire [4:0]  rd_a_sel,
    input  wire [4:0]  rd_b_sel,
    output wire [7:0]  rd_a_data,
    output wire [7:0]  rd_b_data,
    output wire [15:0] rd_word_data,
    input  wire [4:0]  rd_ptr_low_sel,
    output wire [15:0] rd_ptr_data,
    input  wire [4:0]  wr_sel,
    input  wire        wr_byte_en,
    input  wire        wr_word_en,
    input  wire [15:0] wr_data,
    input  wire        wr_ptr_en,
    input  wire [4:0]  wr_ptr_low_sel,
    input  wire [15:0] wr_ptr_data
);

    reg [7:0] regs [0:31];

    // ----------------------------------------------------------------
    // read ports
    // ----------------------------------------------------------------
    assign rd_a_data    = regs[rd_a_sel];
    assign rd_b_data    = regs[rd_b_sel];
    assign rd_word_data = {regs[{rd_a_sel[4:1], 1'b1}], regs[{rd_a_sel[4:1], 1'b0}]};
    assign rd_ptr_data  = {regs[{rd_ptr_low_sel[4:1], 1'b1}], regs[{rd_ptr_low_sel[4:1], 1'b0}]};

    // ----------------------------------------------------------------
    // write port, word writes hit an even/odd pair
    // ----------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (wr_word_en)
        begin
            regs[{wr_sel[4:1], 1'b0}] <= wr_data[7:0];
            regs[{wr_sel[4:1], 1'b1}] <= wr_data[15:8];
        end
        else if (wr_byte_en)
        begin
            regs[wr_sel] <= wr_data[7:0];
        end
        if (wr_ptr_en)
        begin
            regs[{wr_ptr_low_sel[4:1], 1'b0}] <= wr_ptr_data[7:0];
            regs[{wr_ptr_low_sel[4:1], 1'b1}] <= wr_ptr_data[15:8];
        end
    end

endmodule

//--- testbench/core_state_monitor.sv
/*
 * assertion checker watching the core state ports.
 * assumes a bind onto core_state, one clock, synchronous reset.
 */
`timescale 1ns/1ns
// ------------------------------------------------
// checker
// ------------------------------------------------
module core_state_monitor
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        irq_take,
    input wire logic        set_irq_instr,
    input wire logic        clear_irq_instr,
    input wire logic        return_from_irq_instr,
    input wire logic        irq_allowed,
    input wire logic        alu_valid,
    input wire logic [7:0]  alu_result,
    input wire logic        alu_carry,
    input wire logic [7:0]  alu_flag_mask,
    input wire logic        io_wr_en,
    input wire logic [2:0]  stack_op,
    input wire logic [15:0] stack_ptr,
    input wire logic [15:0] stack_addr,
    input wire logic [7:0]  processor_flags_out
);
    default clocking cb @(posedge core_clk);
    endclocking

    sequence s_at_top;
        stack_addr == stack_ptr;
    endsequence
    sequence s_one_less;
        stack_ptr == $past(stack_ptr) - 16'h0001;
    endsequence
    property p_push;
        disable iff (sys_rst) (stack_op == 3'h1 && !io_wr_en) |-> s_at_top ##1 s_one_less;
    endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_call;
        disable iff (sys_rst) ((stack_op == 3'h3 || stack_op == 3'h5) && !io_wr_en)
            |=> stack_ptr == $past(stack_ptr) - 16'h0002;
    endproperty
    a_call: assert property (p_call) else $error("call step wrong");
    property p_pop;
        disable iff (sys_rst) (stack_op == 3'h2 && !io_wr_en)
            |-> stack_addr == stack_ptr + 16'h0001 ##1 stack_ptr == $past(stack_ptr) + 16'h0001;
    endproperty
    a_pop: assert property (p_pop) else $error("pop step wrong");
    property p_ret;
        disable iff (sys_rst) ((stack_op == 3'h4 || stack_op == 3'h6) && !io_wr_en)
            |=> stack_ptr == $past(stack_ptr) + 16'h0002;
    endproperty
    a_ret: assert property (p_ret) else $error("return step wrong");
    property p_sign;
        disable iff (sys_rst) processor_flags_out[4] == (processor_flags_out[2] ^ processor_flags_out[3]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");
    property p_gate;
        disable iff (sys_rst) !processor_flags_out[7] |-> !irq_allowed;
    endproperty
    a_gate: assert property (p_gate) else $error("interrupt allowed while disabled");
    property p_take;
        disable iff (sys_rst) (irq_take && irq_allowed && !set_irq_instr && !return_from_irq_instr && !io_wr_en)
            |=> !processor_flags_out[7];
    endproperty
    a_take: assert property (p_take) else $error("enable kept on entry");
    property p_return_from_irq_instr;
        disable iff (sys_rst) (return_from_irq_instr && !clear_irq_instr && !irq_take && !io_wr_en)
            |=> processor_flags_out[7];
    endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("enable not set on return");
    property p_cli;
        disable iff (sys_rst) clear_irq_instr |=> !processor_flags_out[7];
    endproperty
    a_cli: assert property (p_cli) else $error("enable not cleared");
    property p_zero;
        disable iff (sys_rst) (alu_valid && alu_flag_mask[1] && !io_wr_en)
            |=> processor_flags_out[1] == ($past(alu_result) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_neg;
        disable iff (sys_rst) (alu_valid && alu_flag_mask[2] && !io_wr_en)
            |=> {7'h00, processor_flags_out[2]} == ($past(alu_result) >> 7);
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    property p_carry;
        disable iff (sys_rst) (alu_valid && alu_flag_mask[0] && !io_wr_en)
            |=> processor_flags_out[0] == $past(alu_carry);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    property p_rst;
        sys_rst |=> stack_ptr == 16'h0000 && processor_flags_out == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

//--- testbench/core_state_tb.sv
/*
 * self-checking bench for core_state.
 * assumes the checker and adder model files are compiled first.
 */
`timescale 1ns/1ns
module core_state_tb;
    logic        core_clk, sys_rst, irq_pending, irq_take, set_irq_instr, clear_irq_instr;
    logic        return_from_irq_instr, alu_valid, bit_store_instr, bit_load_instr;
    logic        wr_byte_en, wr_word_en, ptr_en, data_wr_en, io_wr_en, io_hit, hit, ph;
    logic        irq_allowed, ptr_hits_regfile, alu_carry, alu_half_carry, alu_overflow;
    logic [2:0]  bit_sel, stack_op;
    logic [1:0]  ptr_sel, ptr_mode;
    logic [4:0]  rd_a_sel, rd_b_sel, wr_sel;
    logic [5:0]  ptr_disp, io_addr;
    logic [7:0]  alu_flag_mask, data_wr, io_wr, op_a, op_b, alu_result, rd;
    logic [7:0]  rd_a_data, rd_b_data, data_rd, io_rd, processor_flags_out;
    logic [15:0] wr_data, data_addr, rd_word_data, ptr_addr, stack_ptr, stack_addr, sp, pa;
    logic [2:0]  ops [6] = '{3'h1, 3'h3, 3'h5, 3'h2, 3'h4, 3'h6};
    logic [15:0] deltas [6] = '{16'hffff, 16'hfffe, 16'hfffe, 16'h0001, 16'h0002, 16'h0002};
    logic [23:0] alu_cases [3] = '{24'h7f012c, 24'hff0123, 24'h018114};
    int          miscompares = 0;
    int          checks = 0;

    core_state u_core_state
    (
        .core_clk, .sys_rst, .irq_pending, .irq_take, .set_irq_instr, .clear_irq_instr,
        .return_from_irq_instr, .irq_allowed, .alu_valid, .alu_result, .alu_carry, .alu_half_carry,
        .alu_overflow, .alu_flag_mask, .bit_store_instr, .bit_load_instr, .bit_sel, .rd_a_sel,
        .rd_b_sel, .rd_a_data, .rd_b_data, .rd_word_data, .wr_sel, .wr_byte_en, .wr_word_en,
        .wr_data, .ptr_en, .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr, .ptr_hits_regfile,
        .data_wr_en, .data_addr, .data_wr, .data_rd, .stack_op, .stack_ptr, .stack_addr,
        .io_addr, .io_wr_en, .io_wr, .io_rd, .io_hit, .processor_flags_out
    );
    exec_unit_model u_exec_unit_model
    (
        .op_a, .op_b, .sum(alu_result), .carry_out(alu_carry), .half_out(alu_half_carry),
        .ovf_out(alu_overflow)
    );

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge core_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        tick; io_addr <= a; io_wr <= d; io_wr_en <= 1'b1;
        tick; io_wr_en <= 1'b0;
    endtask
    task automatic io_read(input logic [5:0] a);
        tick; io_addr <= a;
        #1 rd = io_rd; hit = io_hit;
    endtask
    task automatic ptr_step(input logic [1:0] m, input logic [5:0] d);
        tick; ptr_en <= 1'b1; ptr_sel <= 2'h0; ptr_mode <= m; ptr_disp <= d;
        #1 pa = ptr_addr; ph = ptr_hits_regfile;
        tick; ptr_en <= 1'b0;
        #1;
    endtask
    task automatic word_write(input logic [15:0] d);
        tick; wr_sel <= 5'h1a; wr_data <= d; wr_word_en <= 1'b1; rd_a_sel <= 5'h1a;
        tick; wr_word_en <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        #100000 miscompares++;
        give_verdict;
    end
    initial
    begin
        {sys_rst, irq_pending, irq_take, set_irq_instr, clear_irq_instr} = 5'h10;
        {return_from_irq_instr, alu_valid, bit_store_instr, bit_load_instr} = 4'h0;
        {wr_byte_en, wr_word_en, ptr_en, data_wr_en, io_wr_en} = 5'h00;
        {bit_sel, stack_op, ptr_sel, ptr_mode, rd_a_sel, rd_b_sel, wr_sel} = 25'h0;
        {ptr_disp, io_addr, alu_flag_mask, data_wr, io_wr, op_a, op_b} = 52'h0;
        wr_data = 16'h0000;
        data_addr = 16'h0100;
        repeat (8) tick;
        sys_rst <= 1'b0;
        io_read(6'h3d); check("sp_low", {8'h00, rd}, 16'h0000);
        io_read(6'h3e); check("sp_high", {8'h00, rd}, 16'h0000);
        check("flags", {8'h00, processor_flags_out}, 16'h0000);
        io_read(6'h10); check("io_miss", {7'h00, hit, rd}, 16'h0000);
        foreach (alu_cases[i])
        begin
            tick; op_a <= alu_cases[i][23:16]; op_b <= alu_cases[i][15:8];
            alu_valid <= 1'b1; alu_flag_mask <= 8'h2f;
            tick; alu_valid <= 1'b0;
            #1 check("alu_flags", {8'h00, processor_flags_out}, {8'h00, alu_cases[i][7:0]});
        end
        tick; irq_pending <= 1'b1;
        #1 check("allowed", {15'h0, irq_allowed}, 16'h0000);
        tick; set_irq_instr <= 1'b1; tick; set_irq_instr <= 1'b0;
        #1 check("flags", {8'h00, processor_flags_out}, 16'h0094);
        check("allowed", {15'h0, irq_allowed}, 16'h0001);
        tick; irq_take <= 1'b1; tick; irq_take <= 1'b0;
        #1 check("flags", {8'h00, processor_flags_out}, 16'h0014);
        tick; return_from_irq_instr <= 1'b1; tick; return_from_irq_instr <= 1'b0;
        #1 check("flags", {8'h00, processor_flags_out}, 16'h0094);
        tick; clear_irq_instr <= 1'b1;
        #1 check("allowed", {15'h0, irq_allowed}, 16'h0000);
        tick; clear_irq_instr <= 1'b0;
        #1 check("flags", {8'h00, processor_flags_out}, 16'h0014);
        io_write(6'h3e, 8'h02);
        io_write(6'h3d, 8'h01);
        io_read(6'h3e); check("sp_high", {8'h00, rd}, 16'h0002);
        io_read(6'h3d); check("sp_low", {8'h00, rd}, 16'h0001);
        sp = 16'h0201;
        foreach (ops[i])
        begin
            tick; stack_op <= ops[i];
            pa = sp + {15'h0, ops[i] == 3'h2 || ops[i] == 3'h4 || ops[i] == 3'h6};
            #1 check("stack_addr", stack_addr, pa);
            sp = sp + deltas[i];
            tick; stack_op <= 3'h0;
            #1 check("stack_ptr", stack_ptr, sp);
        end
        word_write(16'h1234);
        check("word", rd_word_data, 16'h1234);
        check("byte", {8'h00, rd_a_data}, 16'h0034);
        ptr_step(2'h1, 6'h00); check("post_inc", pa, 16'h1234); check("ptr", rd_word_data, 16'h1235);
        ptr_step(2'h2, 6'h00); check("pre_dec", pa, 16'h1234); check("ptr", rd_word_data, 16'h1234);
        ptr_step(2'h3, 6'h3f); check("disp", pa, 16'h1273); check("ptr", rd_word_data, 16'h1234);
        word_write(16'h0020);
        ptr_step(2'h2, 6'h00); check("hit", {ph, pa[14:0]}, 16'h801f);
        tick; data_addr <= 16'h0005; data_wr <= 8'ha5; data_wr_en <= 1'b1; rd_a_sel <= 5'h05;
        tick; data_wr_en <= 1'b0;
        #1 check("data_rd", {data_rd, rd_a_data}, 16'ha5a5);
        tick; bit_store_instr <= 1'b1; bit_sel <= 3'h0; tick; bit_store_instr <= 1'b0;
        #1 check("flags", {8'h00, processor_flags_out}, 16'h0054);
        tick; bit_load_instr <= 1'b1; bit_sel <= 3'h1; tick; bit_load_instr <= 1'b0;
        #1 check("bit_load", {8'h00, rd_a_data}, 16'h00a7);
        tick; wr_sel <= 5'h1e; wr_data <= 16'h0abc; wr_word_en <= 1'b1; ptr_sel <= 2'h2; ptr_mode <= 2'h0;
        tick; wr_word_en <= 1'b0;
        #1 check("z_ptr", ptr_addr, 16'h0abc);
        tick; wr_sel <= 5'h1d; wr_data <= 16'h00c3; wr_byte_en <= 1'b1; rd_a_sel <= 5'h1d; ptr_sel <= 2'h1;
        tick; wr_byte_en <= 1'b0;
        #1 check("y_high", {rd_a_data, ptr_addr[15:8]}, 16'hc3c3);
        io_write(6'h3f, 8'h0b);
        tick; irq_take <= 1'b1;
        tick; irq_take <= 1'b0;
        io_read(6'h3f); check("flags_io", {7'h00, hit, rd}, 16'h011b);
        give_verdict;
    end
endmodule

bind core_state core_state_monitor u_core_state_monitor
(
    .core_clk, .sys_rst, .irq_take, .set_irq_instr, .clear_irq_instr, .return_from_irq_instr,
    .irq_allowed, .alu_valid, .alu_result, .alu_carry, .alu_flag_mask, .io_wr_en, .stack_op,
    .stack_ptr, .stack_addr, .processor_flags_out
);

//--- testbench/exec_unit_model.sv
/*
 * adder standing in for the execution unit and alu.
 * assumes its outputs feed the alu inputs of core_state.
 */
`timescale 1ns/1ns
// ------------------------------------------------
// adder model
// ------------------------------------------------
module exec_unit_model
(
    input  wire logic [7:0] op_a,
    input  wire logic [7:0] op_b,
    output wire logic [7:0] sum,
    output wire logic       carry_out,
    output wire logic       half_out,
    output wire logic       ovf_out
);
    logic [8:0] full;
    logic [4:0] low;
    assign full      = {1'b0, op_a} + {1'b0, op_b};
    assign low       = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
    assign sum       = full[7:0];
    assign carry_out = full[8];
    assign half_out  = low[4];
    assign ovf_out   = (op_a[7] == op_b[7]) && (full[7] != op_a[7]);
endmodule
